// ==== design/sfbc_pkg.sv ====
/*
 * shared constants, types and helper functions of the serial frame and
 * baud configuration block: register offsets, bit positions, reset values,
 * state encodings and the bus request carrier.
 * assumes a single 10 MHz system clock and a byte-wide register port.
 */
package sfbc_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] SFBC_OFS_STATUS_A  = 3'h0; // status_control_a
    localparam logic [2:0] SFBC_OFS_CONTROL_B = 3'h1; // control_b
    localparam logic [2:0] SFBC_OFS_SHARED    = 3'h2; // frame_format_control / baud_divisor_high
    localparam logic [2:0] SFBC_OFS_BAUD_LOW  = 3'h3; // baud_divisor_low
    localparam logic [2:0] SFBC_OFS_DATA      = 3'h4; // transmit / receive data

    // status_control_a bit positions
    localparam int SFBC_STA_RX_DONE  = 7; // received character waiting
    localparam int SFBC_STA_TX_READY = 5; // transmitter idle, may be written
    localparam int SFBC_STA_PERR     = 2; // parity_error_flag
    localparam int SFBC_STA_DSPEED   = 1; // double_speed_bit

    // control_b bit positions
    localparam int SFBC_CB_SIZE_TOP  = 2; // char_size_top_bit
    localparam int SFBC_CB_RX_NINTH  = 1; // rx_ninth_bit
    localparam int SFBC_CB_TX_NINTH  = 0; // tx_ninth_bit

    // shared location bit positions
    localparam int SFBC_FF_SELECT    = 7; // shared_location_select
    localparam int SFBC_BH_TOP       = 3; // top bit of divisor nibble

    // reset values
    localparam logic [6:0]  SFBC_FF_RESET   = 7'h06; // size 8 bits, async, no parity
    localparam logic [11:0] SFBC_BAUD_RESET = 12'h000;

    // oversampling ratios in asynchronous mode
    localparam logic [3:0] SFBC_RATIO_NORMAL_M1 = 4'hF; // 16 ticks per bit, minus one
    localparam logic [3:0] SFBC_RATIO_DOUBLE_M1 = 4'h7; // 8 ticks per bit, minus one

    // frame geometry
    localparam int SFBC_TX_FRAME_W = 13; // start + 9 data + parity + 2 stop
    localparam int SFBC_RX_FRAME_W = 11; // 9 data + parity + 1 stop

    // frame-format fields below the select bit
    typedef struct packed {
        logic       sync_async_select;   // 0 async, 1 sync
        logic [1:0] parity_type_field;   // 00 off, 10 even, 11 odd
        logic       stop_count_select;   // 0 one stop, 1 two stops
        logic [1:0] char_size_low_bits;  // low bits of size code
        logic       sync_clock_polarity; // launch / sample edge choice
    } sfbc_frame_t;

    // one register port request
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [2:0] addr;  // register offset
        logic [7:0] wdata; // write data
    } sfbc_bus_t;

    typedef enum logic [1:0] {
        SFBC_RX_IDLE  = 2'b00,
        SFBC_RX_START = 2'b01,
        SFBC_RX_DATA  = 2'b11
    } sfbc_rx_state_t;

    typedef enum logic {
        SFBC_TX_IDLE  = 1'b0,
        SFBC_TX_SHIFT = 1'b1
    } sfbc_tx_state_t;

    // data bits per character; reserved codes fall back to 8
    function automatic logic [3:0] sfbc_char_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        if (!code[2]) begin
            n = 4'h5 + {2'b00, code[1:0]};
        end else if (code == 3'h7) begin
            n = 4'h9;
        end
        return n;
    endfunction

    // even parity over the low n bits of a character
    function automatic logic sfbc_parity(input logic [8:0] d, input logic [3:0] n);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

endpackage

// ==== design/sfbc_core.sv ====
/*
 * serial frame and baud configuration block with a compact transmitter,
 * receiver, baud prescaler and synchronous clock master.
 * assumes a synchronous register port with one-cycle strobes, read data
 * one cycle later, and a line input already synchronous to clk.
 */
`timescale 1ns/1ps

// Operation
// (RQ1) frame-format reads show select bit one
// (RQ2) baud-high reads select zero; select-zero writes update
// (RQ3) shared address, write steered by select bit
// (RQ4) mode bit: zero async, one sync
// (RQ5) parity field: off, reserved, even, odd
// (RQ6) transmitter inserts computed parity bit
// (RQ7) receiver checks parity, flags mismatch
// (RQ8) stop select: one or two stop bits
// (RQ9) receiver ignores stop select
// (RQ10) three-bit size code sets 5-9 data bits
// (RQ11) software keeps polarity zero in async mode
// (RQ12) polarity picks launch and sample clock edges
// (RQ13) baud-high bits 14:12 read zero
// (RQ14) 12-bit divisor from high and low, reset zero
// (RQ15) baud-low write reloads prescaler immediately
// (RQ16) software avoids divisor change mid-frame
// (RQ17) double speed drops ratio sixteen to eight
// (RQ18) ninth bit sent from and captured to dedicated bits
// (RQ19) parity error only when checking enabled
// (RQ20) bit period is divisor plus one times ratio
module sfbc_core
    import sfbc_pkg::*;
(
    input  wire logic       clk,     // system clock, 10 MHz
    input  wire logic       srst,    // synchronous reset, active high
    input  wire sfbc_bus_t  bus_req, // register port request
    output logic [7:0]      rd_data, // read data, cycle after read strobe
    output logic            txd,     // serial transmit line
    input  wire logic       rxd,     // serial receive line
    output logic            xck_o,   // sync_serial_clock_pin output level
    output logic            xck_oe   // sync_serial_clock_pin drive enable
);

    // configuration state
    sfbc_frame_t    frame_reg;        // frame_format_control fields
    logic [11:0]    baud_reg;         // baud_divisor
    logic           dspeed_reg;       // double_speed_bit
    logic           size_top_reg;     // char_size_top_bit
    logic           tx9_reg;          // tx_ninth_bit
    logic           shared_sel_reg;   // which view the shared read returns
    // receive results
    logic [7:0]     rxdata_reg;       // received low data bits
    logic           rx9_reg;          // rx_ninth_bit
    logic           rxdone_reg;       // character waiting
    logic           perr_reg;         // parity_error_flag
    // timing
    logic [11:0]    presc_reg;        // baud prescaler count
    logic           xck_reg;          // internal sync clock level
    // transmitter
    sfbc_tx_state_t tx_state_reg;     // transmitter state
    logic [12:0]    tx_shift_reg;     // remaining frame, lsb first
    logic [3:0]     tx_left_reg;      // bits still to launch
    logic [3:0]     tx_sub_reg;       // ticks within a bit
    logic           txd_reg;          // line level
    // receiver
    sfbc_rx_state_t rx_state_reg;     // receiver state
    logic [10:0]    rx_shift_reg;     // collected bits, msb newest
    logic [3:0]     rx_cnt_reg;       // bits sampled so far
    logic [3:0]     rx_sub_reg;       // ticks within a bit
    // outputs
    logic [7:0]     rd_data_reg;      // registered read data
    logic           xck_oe_reg;       // registered clock drive enable

    // decoded controls
    logic           wr_shared;        // write to shared location
    logic           wr_data;          // write to data register
    logic           rd_data_hit;      // read of data register
    logic           tick;             // prescaler wrap
    logic [3:0]     ratio_m1;         // ticks per bit minus one
    logic [3:0]     nbits;            // data bits per character
    logic           par_en;           // parity generated and checked
    logic           par_odd;          // odd parity selected
    logic           launch;           // sync edge that changes data
    logic           sample;           // sync edge that samples data
    logic           tx_step;          // transmitter moves one bit
    logic [12:0]    tx_vec;           // frame built from written data
    logic [3:0]     tx_len;           // frame length in bits
    logic [3:0]     rx_need;          // data plus parity bits, stop bit excluded
    logic           rx_take;          // receiver samples one bit
    logic [10:0]    rx_next;          // shift value after sampling
    logic [10:0]    rx_word;          // aligned received bits
    logic           rx_finish;        // last bit of a character taken

    assign wr_shared   = bus_req.wr && (bus_req.addr == SFBC_OFS_SHARED);
    assign wr_data     = bus_req.wr && (bus_req.addr == SFBC_OFS_DATA);
    assign rd_data_hit = bus_req.rd && (bus_req.addr == SFBC_OFS_DATA);

    // frame settings shared by both directions
    assign nbits    = sfbc_char_bits({size_top_reg, frame_reg.char_size_low_bits}); // RQ10
    assign par_en   = frame_reg.parity_type_field[1];                               // RQ5
    assign par_odd  = frame_reg.parity_type_field[0];                               // RQ5
    assign ratio_m1 = (dspeed_reg && !frame_reg.sync_async_select)
                    ? SFBC_RATIO_DOUBLE_M1 : SFBC_RATIO_NORMAL_M1;                  // RQ17

    // prescaler wraps every divisor plus one clocks; a divisor lowered below
    // the running count wraps at once instead of waiting out a 4096 rollover
    assign tick   = (presc_reg >= baud_reg);                                        // RQ20
    // polarity zero: launch on rising, sample on falling
    assign launch = tick && frame_reg.sync_async_select
                  && (xck_reg == frame_reg.sync_clock_polarity);                    // RQ12
    assign sample = tick && frame_reg.sync_async_select
                  && (xck_reg != frame_reg.sync_clock_polarity);                    // RQ12

    // register writes to configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_reg      <= SFBC_FF_RESET;
            baud_reg       <= SFBC_BAUD_RESET;                                      // RQ14
            dspeed_reg     <= 1'b0;
            size_top_reg   <= 1'b0;
            tx9_reg        <= 1'b0;
            shared_sel_reg <= 1'b1;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                SFBC_OFS_STATUS_A: begin
                    dspeed_reg <= bus_req.wdata[SFBC_STA_DSPEED];
                end
                SFBC_OFS_CONTROL_B: begin
                    size_top_reg <= bus_req.wdata[SFBC_CB_SIZE_TOP];
                    tx9_reg      <= bus_req.wdata[SFBC_CB_TX_NINTH];
                end
                SFBC_OFS_SHARED: begin
                    // select bit steers the write
                    if (bus_req.wdata[SFBC_FF_SELECT]) begin                        // RQ3
                        frame_reg      <= bus_req.wdata[6:0];                       // RQ1
                        shared_sel_reg <= 1'b1;
                    end else begin
                        baud_reg[11:8] <= bus_req.wdata[SFBC_BH_TOP:0];             // RQ2
                        shared_sel_reg <= 1'b0;
                    end
                end
                SFBC_OFS_BAUD_LOW: begin
                    baud_reg[7:0] <= bus_req.wdata;                                 // RQ14
                end
                default: begin
                    // data and unmapped offsets leave configuration alone
                end
            endcase
        end
    end

    // register read port, data valid only in the following cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_reg <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                SFBC_OFS_STATUS_A: begin
                    rd_data_reg <= {rxdone_reg, 1'b0, (tx_state_reg == SFBC_TX_IDLE),
                                    2'b00, perr_reg, dspeed_reg, 1'b0};
                end
                SFBC_OFS_CONTROL_B: begin
                    rd_data_reg <= {5'h00, size_top_reg, rx9_reg, tx9_reg};
                end
                SFBC_OFS_SHARED: begin
                    if (shared_sel_reg) begin
                        rd_data_reg <= {1'b1, frame_reg};                           // RQ1
                    end else begin
                        rd_data_reg <= {4'h0, baud_reg[11:8]};                      // RQ2 RQ13
                    end
                end
                SFBC_OFS_BAUD_LOW: begin
                    rd_data_reg <= baud_reg[7:0];
                end
                SFBC_OFS_DATA: begin
                    rd_data_reg <= rxdata_reg;
                end
                default: begin
                    rd_data_reg <= 8'h00;
                end
            endcase
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    // baud prescaler, restarted by a low divisor write
    always_ff @(posedge clk) begin
        if (srst) begin
            presc_reg <= 12'h000;
        end else if (bus_req.wr && (bus_req.addr == SFBC_OFS_BAUD_LOW)) begin
            presc_reg <= 12'h000;                                                   // RQ15
        end else if (tick) begin
            presc_reg <= 12'h000;                                                   // RQ20
        end else begin
            presc_reg <= presc_reg + 12'h001;
        end
    end

    // synchronous clock master, idles at polarity level in async mode
    always_ff @(posedge clk) begin
        if (srst) begin
            xck_reg    <= 1'b0;
            xck_oe_reg <= 1'b0;
        end else begin
            xck_oe_reg <= frame_reg.sync_async_select;                              // RQ4
            if (!frame_reg.sync_async_select) begin
                xck_reg <= frame_reg.sync_clock_polarity;
            end else if (tick) begin
                xck_reg <= ~xck_reg;                                                // RQ12
            end
        end
    end

    // frame assembly: start, data, optional parity, one or two stops
    always_comb begin
        tx_vec    = {SFBC_TX_FRAME_W{1'b1}};
        tx_vec[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nbits)) begin
                tx_vec[1 + i] = (i == 8) ? tx9_reg : bus_req.wdata[i];              // RQ18
            end
        end
        if (par_en) begin
            tx_vec[nbits + 4'h1] = sfbc_parity({tx9_reg, bus_req.wdata}, nbits)
                                   ^ par_odd;                                       // RQ6
        end
        tx_len = 4'h2 + nbits + {3'b000, par_en}
               + {3'b000, frame_reg.stop_count_select};                             // RQ8
    end

    // one bit per ratio ticks async, one per launch edge sync
    assign tx_step = frame_reg.sync_async_select ? launch
                   : (tick && (tx_sub_reg == ratio_m1));                            // RQ17 RQ20

    // transmitter
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state_reg <= SFBC_TX_IDLE;
            tx_shift_reg <= {SFBC_TX_FRAME_W{1'b1}};
            tx_left_reg  <= 4'h0;
            tx_sub_reg   <= 4'h0;
            txd_reg      <= 1'b1;
        end else begin
            if (tick) begin
                tx_sub_reg <= (tx_sub_reg == ratio_m1) ? 4'h0 : tx_sub_reg + 4'h1;
            end
            unique case (tx_state_reg)
                SFBC_TX_IDLE: begin
                    // writes while busy are ignored
                    if (wr_data) begin
                        tx_state_reg <= SFBC_TX_SHIFT;
                        tx_shift_reg <= tx_vec;
                        tx_left_reg  <= tx_len;
                        tx_sub_reg   <= 4'h0;
                    end
                end
                SFBC_TX_SHIFT: begin
                    if (tx_step) begin
                        if (tx_left_reg == 4'h0) begin
                            tx_state_reg <= SFBC_TX_IDLE;
                            txd_reg      <= 1'b1;
                        end else begin
                            txd_reg      <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
                            tx_left_reg  <= tx_left_reg - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // receiver frame length never counts a second stop bit
    assign rx_need = nbits + {3'b000, par_en};                                      // RQ9
    assign rx_next = {rxd, rx_shift_reg[10:1]};
    assign rx_word = rx_next >> (4'hA - rx_need);
    assign rx_take = (rx_state_reg == SFBC_RX_DATA)
                   && (frame_reg.sync_async_select ? sample
                       : (tick && (rx_sub_reg == ratio_m1)));                       // RQ12
    assign rx_finish = rx_take && (rx_cnt_reg == rx_need);

    // receiver sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state_reg <= SFBC_RX_IDLE;
            rx_shift_reg <= 11'h000;
            rx_cnt_reg   <= 4'h0;
            rx_sub_reg   <= 4'h0;
        end else begin
            unique case (rx_state_reg)
                SFBC_RX_IDLE: begin
                    rx_cnt_reg <= 4'h0;
                    rx_sub_reg <= 4'h0;
                    if (!rxd && (!frame_reg.sync_async_select || sample)) begin     // RQ4
                        rx_state_reg <= frame_reg.sync_async_select
                                      ? SFBC_RX_DATA : SFBC_RX_START;
                    end
                end
                SFBC_RX_START: begin
                    // confirm start bit at its middle
                    if (tick) begin
                        rx_sub_reg <= rx_sub_reg + 4'h1;
                        if (rx_sub_reg == {1'b0, ratio_m1[3:1]}) begin
                            rx_sub_reg   <= 4'h0;
                            rx_state_reg <= rxd ? SFBC_RX_IDLE : SFBC_RX_DATA;
                        end
                    end
                end
                SFBC_RX_DATA: begin
                    if (tick) begin
                        rx_sub_reg <= (rx_sub_reg == ratio_m1) ? 4'h0 : rx_sub_reg + 4'h1;
                    end
                    if (rx_take) begin
                        rx_shift_reg <= rx_next;
                        rx_cnt_reg   <= rx_cnt_reg + 4'h1;
                        if (rx_finish) begin
                            rx_state_reg <= SFBC_RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_reg <= SFBC_RX_IDLE;
                end
            endcase
        end
    end

    // received character results; a new character wins over a data read
    always_ff @(posedge clk) begin
        if (srst) begin
            rxdata_reg <= 8'h00;
            rx9_reg    <= 1'b0;
            rxdone_reg <= 1'b0;
            perr_reg   <= 1'b0;
        end else if (rx_finish) begin
            rxdata_reg <= rx_word[7:0] & (8'hFF >> (4'h8 - ((nbits > 4'h8) ? 4'h8 : nbits)));
            rx9_reg    <= (nbits == 4'h9) ? rx_word[8] : 1'b0;                      // RQ18
            rxdone_reg <= 1'b1;
            perr_reg   <= par_en && ((sfbc_parity(rx_word[8:0], nbits) ^ par_odd)
                          != rx_word[nbits]);                                       // RQ7 RQ19
        end else if (rd_data_hit) begin
            rxdone_reg <= 1'b0;
            perr_reg   <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign rd_data = rd_data_reg;
    assign txd     = txd_reg;
    assign xck_o   = xck_reg;
    assign xck_oe  = xck_oe_reg;

endmodule

// ==== tb/sfbc_props.sv ====
/* checker: register answers, bit timing, clock pin.
   assumes config stays fixed per frame. */
`timescale 1ns/1ps
module sfbc_props
    import sfbc_pkg::*;
(
    input wire logic       clk,     // system clock
    input wire logic       srst,    // sync reset
    input wire sfbc_bus_t  bus_req, // register request
    input wire logic [7:0] rd_data, // read data
    input wire logic       txd,     // serial out
    input wire logic       rxd,     // serial in
    input wire logic       xck_o,   // clock pin level
    input wire logic       xck_oe   // clock pin enable
);
    logic        sel_reg;  // shared select
    logic        mode_reg; // sync mode
    logic        pol_reg;  // polarity
    logic        ds_reg;   // double speed
    logic [11:0] div_reg;  // divisor
    logic [7:0]  wd;       // write data
    logic        shr_wr;   // shared write
    logic        fast;     // async, divisor zero
    assign wd = bus_req.wdata;
    assign shr_wr = bus_req.wr && bus_req.addr == SFBC_OFS_SHARED;
    assign fast = !xck_oe && div_reg == 12'h000;
    // mirror of what software wrote
    always_ff @(posedge clk) begin
        if (srst) begin
            {sel_reg, mode_reg, pol_reg, ds_reg, div_reg} <= 16'h8000;
        end else begin
            if (shr_wr) sel_reg <= wd[7];
            if (shr_wr && wd[7]) {mode_reg, pol_reg} <= {wd[6], wd[0]};
            if (shr_wr && !wd[7]) div_reg[11:8] <= wd[3:0];
            if (bus_req.wr && bus_req.addr == SFBC_OFS_BAUD_LOW) div_reg[7:0] <= wd;
            if (bus_req.wr && bus_req.addr == SFBC_OFS_STATUS_A) ds_reg <= wd[1];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence shr_rd; bus_req.rd && bus_req.addr == SFBC_OFS_SHARED; endsequence
    sequence hold15; $stable(txd)[*8] ##1 $stable(txd)[*7]; endsequence
    sequence hold7; $stable(txd)[*7]; endsequence
    a_frame_sel_one: assert property (
        shr_rd ##0 sel_reg |=> rd_data[7]) else $error("select not one");
    a_high_sel_zero: assert property (
        shr_rd ##0 !sel_reg |=> rd_data[7:4] == 4'h0) else $error("high top set");
    a_high_value: assert property (
        shr_rd ##0 !sel_reg |=> rd_data[3:0] == div_reg[11:8]) else $error("high wrong");
    a_low_value: assert property (
        bus_req.rd && bus_req.addr == SFBC_OFS_BAUD_LOW |=> rd_data == div_reg[7:0])
        else $error("low wrong");
    a_unmapped_zero: assert property (
        bus_req.rd && bus_req.addr > 3'h4 |=> rd_data == 8'h00) else $error("unmapped");
    a_mode_drive: assert property (
        mode_reg == $past(mode_reg) && mode_reg == $past(mode_reg, 2) |-> xck_oe == mode_reg)
        else $error("enable wrong");
    a_async_level: assert property (
        !xck_oe && !$past(xck_oe) |-> xck_o == pol_reg) else $error("idle level");
    a_sync_toggle: assert property (
        xck_oe && $past(xck_oe, 2) && div_reg == 12'h000 |-> xck_o != $past(xck_o))
        else $error("no toggle");
    a_bit_len16: assert property (
        $changed(txd) && fast && !ds_reg |=> hold15) else $error("bit under 16");
    a_bit_len8: assert property (
        $changed(txd) && fast && ds_reg |=> hold7) else $error("bit under 8");
endmodule

// ==== tb/sfbc_line_partner.sv ====
/* line partner: drives rxd, captures txd frames.
   assumes idle-high line, period in clk cycles. */
`timescale 1ns/1ps
module sfbc_line_partner (
    input  wire logic clk, // system clock
    input  wire logic txd, // line from the block
    output logic      rxd  // line to the block
);
    initial rxd = 1'b1; // idle level
    // lsb first, then idle
    task automatic send(input int p, input int ns, input logic [12:0] f);
        for (int i = 0; i < ns; i++) begin
            @(posedge clk) rxd <= f[i];
            repeat (p - 1) @(posedge clk);
        end
        @(posedge clk) rxd <= 1'b1;
    endtask
    // find start, sample mid-bit
    task automatic grab(input int p, input int ns, output logic [12:0] f);
        int t;
        f = '1;
        for (t = 0; txd !== 1'b0 && t < 4000; t++) @(negedge clk);
        repeat (p / 2) @(negedge clk);
        for (int i = 0; i < ns; i++) begin
            f[i] = txd;
            repeat (p) @(negedge clk);
        end
    endtask
endmodule

// ==== tb/test_sfbc_core.sv ====
/* bench: registers, tx and rx frames, clock pin.
   assumes partner and checker compiled first. */
`timescale 1ns/1ps
module test_sfbc_core;
    import sfbc_pkg::*;
    logic       clk = 1'b0;   // 10 MHz
    logic       srst = 1'b1;  // sync reset
    sfbc_bus_t  bus_req = '0; // register request
    logic [7:0] rd_data;      // read data
    logic       txd, rxd, xck_o, xck_oe; // dut pins
    int         num_errors = 0, num_checks = 0;
    int         cyc = 0;      // cycle count
    logic [2:0] cs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5}; // size codes
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    sfbc_core dut (.clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .txd(txd), .rxd(rxd), .xck_o(xck_o), .xck_oe(xck_oe));
    sfbc_line_partner peer (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk) bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic int nbits(input logic [2:0] c);
        return c[2] ? ((c == 3'h7) ? 9 : 8) : 5 + int'(c[1:0]);
    endfunction
    // expected line frame
    function automatic logic [12:0] frame(input logic [8:0] d, input int n, input logic [1:0] p);
        logic [12:0] f;
        f = 13'h1FFE;
        for (int i = 0; i < n; i++) f[i + 1] = d[i];
        if (p[1]) f[n + 1] = ^(d & 9'((1 << n) - 1)) ^ p[0];
        return f;
    endfunction
    // send, capture, time to ready
    task automatic tx(input logic [2:0] c, input logic [1:0] p, input logic s,
                      input int per, output int n);
        logic [8:0]  d;
        logic [12:0] g;
        logic [7:0]  st;
        int          t0;
        d = 9'($urandom);
        wr(3'h1, {5'h00, c[2], 1'b0, d[8]});
        wr(3'h2, {2'b10, p, s, c[1:0], 1'b0});
        wr(3'h3, 8'(per / 24));
        fork
            peer.grab(per, nbits(c) + 2 + int'(p[1]), g);
        join_none
        wr(3'h4, d[7:0]);
        t0 = cyc;
        st = 8'h00;
        while (st[5] !== 1'b1 && cyc - t0 < 3000) rd(3'h0, st);
        n = cyc - t0;
        wait fork;
        chk("tx frame", frame(d, nbits(c), p), g);
        repeat (40) @(posedge clk);
    endtask
    initial begin
        logic [7:0]  v, e, st;
        logic [8:0]  d;
        logic [12:0] f;
        logic [2:0]  c;
        logic [1:0]  p;
        int          n0, n1, per;
        void'($urandom(32'h70852add));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(3'h2, v);
        chk("shared reset", 13'h086, 13'(v));
        rd(3'h3, v);
        chk("baud low reset", 13'h000, 13'(v));
        e = 8'($urandom_range(5, 7));
        wr(e[2:0], 8'hFF);
        rd(e[2:0], v);
        chk("unmapped", 13'h000, 13'(v));
        e = 8'($urandom) & 8'h0F;
        wr(3'h2, e);
        rd(3'h2, v);
        chk("baud high", 13'(e), 13'(v));
        wr(3'h2, 8'h00);
        wr(3'h2, 8'hC6);
        repeat (4) @(negedge clk);
        chk("sync enable", 13'h001, 13'(xck_oe));
        rd(3'h2, v);
        chk("frame read", 13'h0C6, 13'(v));
        wr(3'h2, 8'h86);
        for (int i = 0; i < 6; i++) begin
            c = cs[i];
            p = 2'(i);
            wr(3'h0, {6'h00, i == 1, 1'b0});
            per = ((i == 2) ? 3 : 1) * ((i == 1) ? 8 : 16);
            tx(c, p, 1'b0, per, n0);
            tx(c, p, 1'b1, per, n1);
            chk("stop time", 13'(per), 13'(n1 - n0));
        end
        for (int i = 0; i < 8; i++) begin
            c = cs[i % 6];
            p = 2'($urandom);
            d = 9'($urandom) & 9'((1 << nbits(c)) - 1);
            f = frame(d, nbits(c), p);
            f[nbits(c) + 1] ^= i[0] && p[1];
            wr(3'h1, {5'h00, c[2], 2'b00});
            wr(3'h2, {2'b10, p, i[1], c[1:0], 1'b0});
            peer.send(16, nbits(c) + 2 + int'(p[1]), f);
            st = 8'h00;
            for (int t = 0; t < 100 && st[7] !== 1'b1; t++) rd(3'h0, st);
            rd(3'h1, v);
            rd(3'h4, e);
            chk("rx parity flag", 13'(i[0] && p[1]), 13'(st[2]));
            chk("rx data", 13'(d[7:0]), 13'(e));
            if (nbits(c) == 9) chk("rx ninth", 13'(d[8]), 13'(v[1]));
        end
        wrap_up();
    end
    // cut a hang short
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
bind sfbc_core sfbc_props u_props (.clk(clk), .srst(srst), .bus_req(bus_req),
    .rd_data(rd_data), .txd(txd), .rxd(rxd), .xck_o(xck_o), .xck_oe(xck_oe));
